// *** core/rpx_pkg.sv ***
/*
 * Constants and types of the remote eight-bit port expander.
 * Assumes a 100 MHz system clock and a serial bus controller on the link.
 */
package rpx_pkg;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED_NIBBLE = 4'h4;
    localparam logic [6:0] GEN_CALL_ADDR     = 7'h00;
    localparam logic [3:0] BYTE_BITS         = 4'h8;
    localparam logic [3:0] LAST_BIT          = 4'h7;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_RESET        = 8'hff;
    localparam logic [7:0] PULL_RESET        = 8'h00;
    localparam logic       LINE_IDLE         = 1'h1;
    localparam logic [3:0] CNT_RESET         = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int T_BUS_FREE_NS   = 4700;
    localparam int T_START_SU_NS   = 4700;
    localparam int T_START_HD_NS   = 4000;
    localparam int T_VALID_NS      = 4000;
    // Longest times round down to whole cycles
    localparam int T_VALID_CYC     = T_VALID_NS / CLK_PERIOD_NS;
    // Least times round up to whole cycles
    localparam int T_BUS_FREE_CYC  = (T_BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_START_SU_CYC  = (T_START_SU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_START_HD_CYC  = (T_START_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } rpx_state_t;

    typedef struct packed {
        rpx_state_t  state;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_s3;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_s3;
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_s3;
        logic [7:0]  pins_s1;
        logic [7:0]  pins_s2;
        logic [2:0]  sel_s1;
        logic [2:0]  sel_s2;
        logic [7:0]  shift;
        logic [3:0]  cnt;
        logic        rw;
        logic        mack;
        logic [7:0]  latch;
        logic [7:0]  pull;
        logic [7:0]  ref_lvl;
        logic        sda_oe_n;
        logic        alert_oe_n;
        logic [7:0]  pins_out;
        logic [7:0]  pins_oe_n;
        logic [7:0]  weak_pu;
    } rpx_sys_t;

    typedef struct packed {
        logic bit_v;
        logic tog;
    } rpx_link_t;

endpackage

// *** core/rpx_port.sv ***
/*
 * Remote eight-bit quasi-bidirectional port behind a two-wire serial target.
 * Assumes open-drain wiring of the serial data line and the alert line is
 * resolved outside, and that the serial clock is driven by the controller.
 */
`timescale 1ns/1ps

// Function
// [R1] Controller leaves the bus idle at least 4.7 us between stop and start.
// [R2] Controller sets up a start or repeated start at least 4.7 us ahead.
// [R3] Controller holds a start at least 4 us before pulling the clock low.
// [R4] Any edge on an input pin asserts the alert within 4 us.
// [R5] Alert releases when pins return to original levels or port is accessed.
// [R6] Alert clears at the acknowledge bit of a read or a write.
// [R7] After clearing, later pin changes are detected and re-assert the alert.
// [R8] Transfers to other targets leave the alert state unchanged.
// [R9] No configuration registers; the data byte maps straight onto the pins.
// [R10] Writing a high turns on a strong pull-up until the next clock fall.
// [R11] Controller writes a high to a pin before using it as input.
// [R12] A transfer begins with data falling while the clock is high.
// [R13] Address byte arrives most significant bit first, direction bit last.
// [R14] The general call address is never acknowledged.
// [R15] Own address is acknowledged by holding data low during the clock high.
// [R16] Address select inputs stay stable from start to stop.
// [R17] Direction high returns pin levels; direction low takes a byte to output.
// [R18] One data byte is acknowledged; further written bytes are ignored.
// [R19] Outputs update only after a whole acknowledged byte, within 4 us.
// [R20] A transfer ends with data rising while the clock is high; back to idle.
// [R21] Answers write addresses 0x40 to 0x4E and read addresses 0x41 to 0x4F.
// [R22] An early stop keeps the last latched outputs and drops partial data.
// [R23] Pins are quasi-bidirectional; a read returns the actual pin level.
module rpx_port (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    output logic             alert_out,
    output logic             alert_oe_n_out,
    input  wire logic [2:0]  address_select_pins_in,
    input  wire logic [7:0]  port_pins_in,
    output logic      [7:0]  port_pins_out,
    output logic      [7:0]  port_pins_oe_n_out,
    output logic      [7:0]  port_weak_pullup_out
);
    import rpx_pkg::*;

    // ------------------------------------------------------------
    // Reset images
    // ------------------------------------------------------------
    localparam rpx_sys_t SYS_RST = '{
        state      : ST_IDLE,
        scl_s1     : LINE_IDLE,
        scl_s2     : LINE_IDLE,
        scl_s3     : LINE_IDLE,
        sda_s1     : LINE_IDLE,
        sda_s2     : LINE_IDLE,
        sda_s3     : LINE_IDLE,
        tog_s1     : 1'h0,
        tog_s2     : 1'h0,
        tog_s3     : 1'h0,
        pins_s1    : PORT_RESET,
        pins_s2    : PORT_RESET,
        sel_s1     : 3'h0,
        sel_s2     : 3'h0,
        shift      : 8'h00,
        cnt        : CNT_RESET,
        rw         : 1'h0,
        mack       : 1'h1,
        latch      : PORT_RESET,
        pull       : PULL_RESET,
        ref_lvl    : PORT_RESET,
        sda_oe_n   : LINE_IDLE,
        alert_oe_n : LINE_IDLE,
        pins_out   : PULL_RESET,
        pins_oe_n  : PORT_RESET,
        weak_pu    : PORT_RESET
    };

    localparam rpx_link_t LINK_RST = '{
        bit_v : 1'h0,
        tog   : 1'h0
    };

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rpx_sys_t  q;
    rpx_sys_t  d;
    rpx_link_t l_q;
    rpx_link_t l_d;

    // Own address check on the received address byte; the general call
    // test stays although the fixed nibble already refuses address zero.
    function automatic logic rpx_addr_match(input logic [7:0] addr_byte,
                                            input logic [2:0] sel);
        rpx_addr_match = (addr_byte[7:4] == ADDR_FIXED_NIBBLE)         // [R21]
                      && (addr_byte[3:1] == sel)                       // [R21]
                      && (addr_byte[7:1] != GEN_CALL_ADDR);            // [R14]
    endfunction

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // Crossing: the link side owns one data bit and one toggle. Only the
    // toggle is synchronised; the bit is read after the toggle edge is
    // seen, when it has been stable for several system clocks. The
    // serial clock must stay high and low for a few system clocks each,
    // or this hand-over breaks.
    //
    // Sample data on each rising clock and flip the toggle; the bit
    // stays put for a whole clock period, so it is stable when the
    // system domain sees the toggle change.
    always_comb begin
        l_d       = l_q;
        l_d.bit_v = sda_in;                                            // [R13]
        l_d.tog   = ~l_q.tog;
    end

    // Link registers, clocked by the serial clock itself
    always_ff @(posedge scl_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            l_q <= LINK_RST;
        end else begin
            l_q <= l_d;
        end
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    // A clock rise is seen about three system clocks after the pin
    // edge, through the toggle path, and a fall about three clocks
    // after it, through the line synchroniser. Both paths are equally
    // deep, so a rise is always handled before the following fall.
    // Start and stop use the same delayed copies of both lines, so
    // close data and clock edges are ordered consistently.
    // Nothing here counts long spans; the bus itself paces all waits.
    // Bus engine, port latch and alert tracking
    always_comb begin
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic rise;
        logic rbit;
        scl_fall = 1'h0;
        start_c  = 1'h0;
        stop_c   = 1'h0;
        rise     = 1'h0;
        rbit     = 1'h0;
        d        = q;

        // Synchronisers for pins and the link toggle
        d.scl_s1  = scl_in;
        d.scl_s2  = q.scl_s1;
        d.scl_s3  = q.scl_s2;
        d.sda_s1  = sda_in;
        d.sda_s2  = q.sda_s1;
        d.sda_s3  = q.sda_s2;
        d.tog_s1  = l_q.tog;
        d.tog_s2  = q.tog_s1;
        d.tog_s3  = q.tog_s2;
        d.pins_s1 = port_pins_in;
        d.pins_s2 = q.pins_s1;
        d.sel_s1  = address_select_pins_in;
        d.sel_s2  = q.sel_s1;

        // Bus events
        scl_fall = q.scl_s3 & ~q.scl_s2;
        start_c  = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;         // [R12]
        stop_c   = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;         // [R20]
        rise     = q.tog_s2 ^ q.tog_s3;
        rbit     = l_q.bit_v;

        // Strong pull-up lasts only until the next clock fall
        if (scl_fall) begin
            d.pull = PULL_RESET;                                       // [R10]
        end

        // Sequencer: states wait on bus events only; a start or stop
        // below overrides the case, so a cut frame ends in a known state.
        unique case (q.state)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (rise) begin
                    d.shift = {q.shift[6:0], rbit};                    // [R13]
                    d.cnt   = q.cnt + 4'h1;
                end
                if (scl_fall && q.cnt == BYTE_BITS) begin
                    if (rpx_addr_match(q.shift, q.sel_s2)) begin
                        d.state    = ST_ADDR_ACK;
                        d.rw       = q.shift[0];
                        d.sda_oe_n = 1'h0;                             // [R15]
                    end else begin
                        d.state    = ST_IGNORE;                        // [R8]
                    end
                end
            end
            ST_ADDR_ACK: begin
                // Read: capture actual pin levels and clear the alert
                if (rise && q.rw) begin
                    d.shift   = q.pins_s2;                             // [R17] [R23]
                    d.ref_lvl = q.pins_s2;                             // [R6]
                end
                if (scl_fall) begin
                    d.cnt = CNT_RESET;
                    if (q.rw) begin
                        d.state    = ST_RD_DATA;
                        d.sda_oe_n = q.shift[7];
                    end else begin
                        d.state    = ST_WR_DATA;
                        d.sda_oe_n = 1'h1;
                    end
                end
            end
            ST_RD_DATA: begin
                if (scl_fall) begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == LAST_BIT) begin
                        d.state    = ST_RD_ACK;
                        d.sda_oe_n = 1'h1;
                    end else begin
                        d.shift    = {q.shift[6:0], 1'h0};
                        d.sda_oe_n = q.shift[6];
                    end
                end
            end
            ST_RD_ACK: begin
                if (rise) begin
                    d.mack = rbit;
                end
                // Controller acknowledge: send a fresh sample of the pins
                if (scl_fall) begin
                    if (!q.mack) begin
                        d.state    = ST_RD_DATA;
                        d.cnt      = CNT_RESET;
                        d.shift    = q.pins_s2;                        // [R23]
                        d.ref_lvl  = q.pins_s2;                        // [R5]
                        d.sda_oe_n = q.pins_s2[7];
                    end else begin
                        d.state    = ST_IGNORE;
                    end
                end
            end
            ST_WR_DATA: begin
                if (rise) begin
                    d.shift = {q.shift[6:0], rbit};
                    d.cnt   = q.cnt + 4'h1;
                end
                if (scl_fall && q.cnt == BYTE_BITS) begin
                    d.state    = ST_WR_ACK;
                    d.sda_oe_n = 1'h0;                                 // [R18]
                end
            end
            ST_WR_ACK: begin
                // Whole byte acknowledged: drive it straight onto the pins
                if (rise) begin
                    d.latch = q.shift;                                 // [R9] [R19]
                    d.pull  = q.shift;                                 // [R10]
                end
                // Re-arm the alert against the settled new levels
                if (scl_fall) begin
                    d.ref_lvl  = q.pins_s2;                            // [R6] [R7]
                    d.sda_oe_n = 1'h1;
                    d.state    = ST_IGNORE;                            // [R18]
                end
            end
            ST_IGNORE: begin
            end
        endcase

        // The latch moves only in the write acknowledge, so a stop in
        // mid-byte leaves the pins alone and the shifted bits unused.
        // Stop ends the transfer; an unfinished byte is simply dropped
        if (stop_c) begin
            d.state    = ST_IDLE;                                      // [R20] [R22]
            d.sda_oe_n = 1'h1;
        end
        // A start or repeated start restarts address reception
        if (start_c) begin
            d.state    = ST_ADDR;                                      // [R12]
            d.cnt      = CNT_RESET;
            d.sda_oe_n = 1'h1;
        end

        // Pins driven low by the latch cannot move, so only pins left
        // high can raise the alert. Transfers to other targets never
        // touch the reference, so they leave the alert as it was.
        // Alert follows any difference from the reference levels; it is
        // held released across the write acknowledge while pins settle.
        if (d.state == ST_WR_ACK) begin
            d.alert_oe_n = 1'h1;                                       // [R6]
        end else begin
            d.alert_oe_n = ~(q.pins_s2 != d.ref_lvl);                  // [R4] [R5] [R7]
        end

        // A latched zero drives low; a latched one leaves the weak
        // pull-up, plus the strong one briefly after a write.
        // Quasi-bidirectional pin drive
        d.pins_oe_n = ~(~d.latch | d.pull);                            // [R23]
        d.pins_out  = d.pull;                                          // [R10]
        d.weak_pu   = d.latch;                                         // [R23]
    end

    // The enable freezes the system side only; the link flops keep
    // running, so traffic while the enable is low is lost.
    // System registers, frozen while the clock enable is low
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= SYS_RST;
        end else if (ce_in) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Only the enables move, so the pads never drive these lines high.
    // Open-drain lines only ever pull low
    assign sda_out              = 1'h0;
    assign alert_out            = 1'h0;
    assign sda_oe_n_out         = q.sda_oe_n;
    assign alert_oe_n_out       = q.alert_oe_n;
    assign port_pins_out        = q.pins_out;
    assign port_pins_oe_n_out   = q.pins_oe_n;
    assign port_weak_pullup_out = q.weak_pu;

endmodule // rpx_port

// *** test/rpx_bus_ctrl.sv ***
/* Serial bus controller model driving clock and data.
   Assumes a pull-up on the data line; the clock stands high outside frames. */
`timescale 1ns/1ps
module rpx_bus_ctrl (
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    // Idle bus
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // Start after bus free time, held before the clock goes low
    task automatic begin_xfer();
        #20 sda_low_out = 1'b0;
        #20 scl_out = 1'b1;
        #4700 sda_low_out = 1'b1;
        #4000 scl_out = 1'b0;
    endtask

    // Send n bits, most significant first, then sample the acknowledge when n is 8
    task automatic tx(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            #20 sda_low_out = ~b[i];
            #20 scl_out = 1'b1;
            #40 scl_out = 1'b0;
        end
        if (n == 8) begin
            #20 sda_low_out = 1'b0;
            #20 scl_out = 1'b1;
            #30 ack = ~sda_in;
            #10 scl_out = 1'b0;
        end
    endtask

    // Receive a byte, then acknowledge or not
    task automatic rx(output logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_low_out = 1'b0;
            #20 scl_out = 1'b1;
            #30 b[i] = sda_in;
            #10 scl_out = 1'b0;
        end
        #20 sda_low_out = ack;
        #20 scl_out = 1'b1;
        #40 scl_out = 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic end_xfer();
        #20 sda_low_out = 1'b1;
        #20 scl_out = 1'b1;
        #4000 sda_low_out = 1'b0;
    endtask
endmodule // rpx_bus_ctrl

// *** test/rpx_port_monitor.sv ***
/* Checker of the port expander pins and serial line.
   Assumes it is bound to rpx_port and sees only its ports. */
`timescale 1ns/1ps
module rpx_port_monitor (
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    input wire logic       ce_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n_out,
    input wire logic       alert_out,
    input wire logic       alert_oe_n_out,
    input wire logic [2:0] address_select_pins_in,
    input wire logic [7:0] port_pins_in,
    input wire logic [7:0] port_pins_out,
    input wire logic [7:0] port_pins_oe_n_out,
    input wire logic [7:0] port_weak_pullup_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Open-drain values and pin drive relations
    property p_sda_od; sda_out == 1'b0; endproperty
    property p_alert_od; alert_out == 1'b0; endproperty
    property p_pull_off;
        $fell(scl_in) |-> ##[1:6] (&(port_pins_oe_n_out | ~port_pins_out));
    endproperty
    property p_low_weak;
        (~port_pins_oe_n_out & ~port_pins_out & port_weak_pullup_out) == 8'h00;
    endproperty
    property p_out_ack; $changed(port_weak_pullup_out) |-> !sda_oe_n_out; endproperty
    property p_alert_cause;
        $fell(alert_oe_n_out) |-> $past(port_pins_in, 6) != port_pins_in;
    endproperty
    property p_alert_rel;
        $rose(alert_oe_n_out) |->
            ($past(port_pins_in, 6) != port_pins_in) || !sda_in || !$past(sda_in, 4);
    endproperty
    property p_sda_hold;
        scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
            |-> $stable(sda_oe_n_out);
    endproperty
    property p_rst_val;
        $rose(reset_n_in) |-> port_pins_oe_n_out == 8'hff &&
            port_weak_pullup_out == 8'hff && sda_oe_n_out && alert_oe_n_out;
    endproperty
    property p_ce_hold;
        !ce_in |=> $stable({alert_oe_n_out, sda_oe_n_out, port_pins_oe_n_out});
    endproperty

    a_sda_od: assert property (p_sda_od)
        else $error("data line value not low");
    a_alert_od: assert property (p_alert_od)
        else $error("alert value not low");
    a_pull_off: assert property (p_pull_off)
        else $error("strong pull-up kept after clock fall");
    a_low_weak: assert property (p_low_weak)
        else $error("weak pull-up on a pin driven low");
    a_out_ack: assert property (p_out_ack)
        else $error("outputs changed outside acknowledge");
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert without pin change");
    a_alert_rel: assert property (p_alert_rel)
        else $error("alert released without cause");
    a_sda_hold: assert property (p_sda_hold)
        else $error("data line moved while clock high");
    a_rst_val: assert property (p_rst_val)
        else $error("wrong values after reset");
    a_ce_hold: assert property (p_ce_hold)
        else $error("state moved while clock enable low");

    // Main scenarios seen
    c_ack: cover property ($fell(sda_oe_n_out));
    c_alert: cover property ($fell(alert_oe_n_out));
    c_pull: cover property (|(~port_pins_oe_n_out & port_pins_out));
endmodule // rpx_port_monitor

bind rpx_port rpx_port_monitor rpx_port_monitor_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out),
    .address_select_pins_in(address_select_pins_in), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe_n_out(port_pins_oe_n_out),
    .port_weak_pullup_out(port_weak_pullup_out));

// *** test/rpx_port_tb_top.sv ***
/* Self-checking bench of the port expander.
   Assumes rpx_port, rpx_bus_ctrl and the bound checker are compiled. */
`timescale 1ns/1ps
module rpx_port_tb_top;
    import rpx_pkg::*;
    logic       clk, rst_n, ce, scl, sda, c_low, sda_o, sda_oe_n, al_o, al_oe_n, ak, k;
    logic [2:0] sel, s;
    logic [7:0] ext, pins, po, oe_n, wp, lat, b, a, d;
    int         mismatches, total_checks;
    logic [19:0] rows [7] = '{
        {3'h0, 8'h40, 8'h5a, 1'b1}, {3'h5, 8'h4a, 8'hc3, 1'b1},
        {3'h7, 8'h4e, 8'h0f, 1'b1}, {3'h7, 8'h4c, 8'hf0, 1'b0},
        {3'h2, 8'h00, 8'hf0, 1'b0}, {3'h3, 8'h56, 8'hf0, 1'b0},
        {3'h3, 8'h46, 8'hff, 1'b1}};

    // Resolved data line and quasi-bidirectional pins
    assign sda = c_low ? 1'b0 : (!sda_oe_n ? sda_o : 1'b1);
    assign pins = (~oe_n & po) | (oe_n & ~ext & wp);

    rpx_port rpx_port_i (
        .clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .alert_out(al_o),
        .alert_oe_n_out(al_oe_n), .address_select_pins_in(sel), .port_pins_in(pins),
        .port_pins_out(po), .port_pins_oe_n_out(oe_n), .port_weak_pullup_out(wp));
    rpx_bus_ctrl rpx_bus_ctrl_i (.scl_out(scl), .sda_low_out(c_low), .sda_in(sda));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t byte %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t flag %b want %b", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One write transfer and its effect on the pins
    task automatic wr(input logic [7:0] wa, input logic [7:0] wd, input logic wk);
        logic ok;
        rpx_bus_ctrl_i.begin_xfer();
        rpx_bus_ctrl_i.tx(wa, 8, ok);
        chk1(ok, wk);
        if (ok === 1'b1) begin
            rpx_bus_ctrl_i.tx(wd, 8, ok);
            chk1(ok, 1'b1);
            lat = wd;
        end
        rpx_bus_ctrl_i.end_xfer();
        repeat (10) @(posedge clk);
        chk8(wp, lat);
        chk8(oe_n, lat);
    endtask

    task automatic wait_chk_alert(input logic e);
        repeat (10) @(posedge clk);
        chk1(al_oe_n, e);
    endtask

    // Watchdog
    initial begin
        #600000;
        mismatches++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        sel = 3'h0;
        ext = 8'h00;
        ce = 1'b1;
        lat = PORT_RESET;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Address table rows; the last writes all high before inputs are used
        for (int i = 0; i < 7; i++) begin
            {s, a, d, k} = rows[i];
            @(posedge clk);
            sel <= s;
            @(posedge clk);
            wr(a, d, k);
            $display("row %0d done", i);
        end
        // Alert raised, kept over other target, cleared by read
        @(posedge clk);
        ext <= 8'h81;
        wait_chk_alert(1'b0);
        wr(8'h40, 8'h00, 1'b0);
        chk1(al_oe_n, 1'b0);
        rpx_bus_ctrl_i.begin_xfer();
        rpx_bus_ctrl_i.tx(8'h47, 8, ak);
        chk1(ak, 1'b1);
        rpx_bus_ctrl_i.rx(b, 1'b1);
        chk8(b, 8'h7e);
        rpx_bus_ctrl_i.rx(b, 1'b0);
        rpx_bus_ctrl_i.end_xfer();
        chk1(al_oe_n, 1'b1);
        @(posedge clk);
        ext <= 8'h00;
        wait_chk_alert(1'b0);
        ext <= 8'h81;
        wait_chk_alert(1'b1);
        ext <= 8'h00;
        $display("alert test done");
        // Second data byte ignored
        rpx_bus_ctrl_i.begin_xfer();
        rpx_bus_ctrl_i.tx(8'h46, 8, ak);
        rpx_bus_ctrl_i.tx(8'h3c, 8, ak);
        chk1(ak, 1'b1);
        rpx_bus_ctrl_i.tx(8'hc3, 8, ak);
        chk1(ak, 1'b0);
        rpx_bus_ctrl_i.end_xfer();
        lat = 8'h3c;
        wait_chk_alert(1'b1);
        chk8(wp, lat);
        $display("extra byte test done");
        // Stop in mid-byte keeps the latch
        rpx_bus_ctrl_i.begin_xfer();
        rpx_bus_ctrl_i.tx(8'h46, 8, ak);
        rpx_bus_ctrl_i.tx(8'h00, 4, ak);
        rpx_bus_ctrl_i.end_xfer();
        repeat (10) @(posedge clk);
        chk8(wp, lat);
        $display("abort test done");
        // Clock enable low freezes the alert; the pin returns before it rises
        ce <= 1'b0;
        ext <= 8'h04;
        wait_chk_alert(1'b1);
        ext <= 8'h00;
        wait_chk_alert(1'b1);
        ce <= 1'b1;
        wait_chk_alert(1'b1);
        $display("enable test done");
        // Reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk8(wp, PORT_RESET);
        chk8(oe_n, 8'hff);
        chk1(al_oe_n, 1'b1);
        chk1(sda_oe_n, 1'b1);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("reset test done");
        stop_test();
    end
endmodule // rpx_port_tb_top
